//--- core/seq_roi_consts.svh
`ifndef SEQ_ROI_CONSTS_SVH
`define SEQ_ROI_CONSTS_SVH

// register address: group in the upper bits, entry index in the lower bits
`define ADDR_W 11
`define GRP_MSB 10
`define GRP_LSB 7
`define IDX_MSB 6
`define IDX_LSB 0
`define MR_IDX_MSB 1
`define MR_IDX_ZERO_MSB 6
`define MR_IDX_ZERO_LSB 2

`define GRP_VBIN 4'h0
`define GRP_LUT_EN 4'h1
`define GRP_BLACK 4'h2
`define GRP_RED 4'h3
`define GRP_BLUE 4'h4
`define GRP_NEXT 4'h5
`define GRP_REPEAT 4'h6
`define GRP_GLOBAL 4'h7
`define GRP_MR_WIDTH 4'h8
`define GRP_MR_HEIGHT 4'h9
`define GRP_MR_XOFF 4'ha
`define GRP_MR_YOFF 4'hb
`define GRP_MR_ROW 4'hc
`define GRP_MR_COL 4'hd

// entries of the global group
`define GLB_SEND_MODE 7'h00
`define GLB_CMD_SELECT 7'h01
`define GLB_CURRENT 7'h02
`define GLB_SEQ_RESET 7'h03
`define GLB_SEQ_LUT_MODE 7'h04
`define GLB_MR_ENABLE 7'h05
`define GLB_LOOKUP_MODE 7'h06
`define GLB_WR_STATUS 7'h07

// permitted ranges
`define VBIN_MIN 32'sh1
`define VBIN_MAX 32'sh2
`define BLACK_MIN (-(32'sh85))
`define BLACK_MAX 32'shff
`define GAIN_MIN (-(32'sh11b5))
`define GAIN_MAX 32'sh4531
`define INDEX_MIN 32'sh1
`define INDEX_MAX 32'sh80
`define REPEAT_MIN 32'sh1
`define REPEAT_MAX 32'shff
`define MR_W_MIN 32'sh10
`define MR_W_MAX 32'sh790
`define MR_H_MIN 32'sh2
`define MR_H_MAX 32'sh4c0
`define MR_X_MAX 32'sh780
`define MR_Y_MAX 32'sh4be
`define FLAG_MAX 32'sh1
`define MODE3_MAX 32'sh2
`define SEQ_RESET_VALUE 32'sh0
`define ZERO_S32 32'sh0

// reset values
`define VBIN_DEFAULT 2'h1
`define MR_W_DEFAULT 11'h790
`define MR_H_DEFAULT 11'h4c0
`define REPEAT_DEFAULT 8'h01
`define INDEX_FIRST 7'h00
`define APPLIED_INDEX 8'h01

`endif

//--- core/seq_roi_pkg.sv
`default_nettype none
package seq_roi_pkg;

    typedef enum logic [1:0] {
        SEND_NORMAL = 2'h0,
        SEND_TRIGGER_SEQ = 2'h1,
        SEND_COMMAND_SEQ = 2'h2
    } send_mode_type;

    typedef enum logic [1:0] {
        LOOKUP_OFF = 2'h0,
        LOOKUP_GAMMA = 2'h1,
        LOOKUP_USER = 2'h2
    } lookup_type;

    typedef struct packed {
        logic [10:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    typedef struct packed {
        send_mode_type mode;
        logic [7:0] index;
        logic [1:0] vbin;
        lookup_type lookup;
        logic signed [8:0] black;
        logic signed [15:0] red_gain;
        logic signed [15:0] blue_gain;
    } applied_type;

endpackage : seq_roi_pkg
`default_nettype wire

//--- core/seq_index_sequencer.sv
`default_nettype none
`include "seq_roi_consts.svh"
module seq_index_sequencer
    import seq_roi_pkg::*;
#(
    parameter int IDX_W = 7
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire send_mode_type mode,
    input wire logic frame_start,
    input wire logic seq_reset,
    input wire logic [IDX_W-1:0] cmd_index,
    input wire logic [7:0] repeat_count,
    input wire logic [IDX_W-1:0] next_index,
    output logic [IDX_W-1:0] current_index
);

    logic [IDX_W-1:0] index_ff;
    logic [7:0] repeat_ff;

    assign current_index = index_ff;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            index_ff <= `INDEX_FIRST; // R20
            repeat_ff <= 8'h00;
        end else if (seq_reset) begin
            index_ff <= `INDEX_FIRST; // R8
            repeat_ff <= 8'h00;
        end else if (frame_start) begin
            case (mode)
                SEND_TRIGGER_SEQ: begin
                    // advance once this index has run its programmed frame count
                    if (repeat_ff + 8'h01 >= repeat_count) begin
                        index_ff <= next_index; // R17 R18
                        repeat_ff <= 8'h00;
                    end else begin
                        repeat_ff <= repeat_ff + 8'h01; // R17
                    end
                end
                SEND_COMMAND_SEQ: begin
                    index_ff <= cmd_index; // R6
                    repeat_ff <= 8'h00;
                end
                default: begin
                    repeat_ff <= 8'h00;
                end
            endcase
        end
    end

endmodule : seq_index_sequencer
`default_nettype wire

//--- core/sequence_roi_parameter_bank.sv
// Function
// R1: each index holds vertical binning, 1 off or 2 twofold (mono only), default 1.
// R2: each index holds a lookup enable flag, default off.
// R3: each index holds signed black offset -133..255, default 0.
// R4: colour variant holds per-index red gain -4533..17713, default 0.
// R5: colour variant holds per-index blue gain -4533..17713, default 0.
// R6: host selects command-sequence index 1..128; following frames use it.
// R7: current index in effect is readable, 1..128, writes ignored.
// R8: writing 0 to sequence reset returns current index to 1.
// R9: in sequence modes enabled lookup uses gamma (mode 0) or user table (1).
// R10: four multi-region widths 16..1936, default 1936; enable flag default 0.
// R11: four multi-region heights 2..1216, default 1216.
// R12: four multi-region x offsets 0..1920, default 0.
// R13: four multi-region y offsets 0..1214, default 0.
// R14: four row and four column include flags, default 0.
// R15: outside sequences global lookup mode: 0 bypass, 1 gamma, 2 user table.
// R16: send modes 0 normal, 1 trigger sequence, 2 command sequence.
// R17: trigger mode repeats index for its frame count 1..255, then advances.
// R18: each index stores its next index 1..128, default 1.
// R19: out-of-range writes are rejected and leave the setting unchanged.
// R20: after reset every parameter holds its default, current index is 1.
`default_nettype none
`include "seq_roi_consts.svh"
module sequence_roi_parameter_bank
    import seq_roi_pkg::*;
#(
    parameter int ENTRIES = 128,
    parameter int MR_COUNT = 4,
    parameter bit COLOR_VARIANT = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire reg_req_type reg_req,
    output logic [31:0] reg_rdata,
    input wire logic frame_start,
    output applied_type applied,
    output logic mr_enable,
    output logic [MR_COUNT-1:0][10:0] mr_width,
    output logic [MR_COUNT-1:0][10:0] mr_height,
    output logic [MR_COUNT-1:0][10:0] mr_x_offset,
    output logic [MR_COUNT-1:0][10:0] mr_y_offset,
    output logic [MR_COUNT-1:0] mr_row_enable,
    output logic [MR_COUNT-1:0] mr_column_enable
);

    // signed bounds check
    function automatic logic in_range(
        input logic signed [31:0] v,
        input logic signed [31:0] lo,
        input logic signed [31:0] hi
    );
        in_range = (v >= lo) &&
            (v <= hi);
    endfunction : in_range

    // index values travel 1-based on the bus and are stored 0-based
    function automatic logic [6:0] to_stored(input logic [31:0] v);
        logic [31:0] t;
        t = v - 32'h1;
        to_stored = t[6:0];
    endfunction : to_stored

    function automatic logic [31:0] to_bus(input logic [6:0] v);
        to_bus = {25'h0, v} + 32'h1;
    endfunction : to_bus

    logic [1:0] seq_vertical_binning_ff [ENTRIES];
    logic seq_index_lookup_enable_ff [ENTRIES];
    logic signed [8:0] seq_black_offset_ff [ENTRIES];
    logic signed [15:0] seq_red_gain_ff [ENTRIES];
    logic signed [15:0] seq_blue_gain_ff [ENTRIES];
    logic [6:0] seq_next_index_ff [ENTRIES];
    logic [7:0] seq_frame_repeat_ff [ENTRIES];

    logic [1:0] video_send_mode_ff;
    logic [6:0] command_seq_select_ff;
    logic seq_lookup_mode_ff;
    logic multi_region_enable_ff;
    logic [1:0] global_lookup_mode_ff;
    logic wr_rejected_ff;

    logic [10:0] multi_region_width_ff [MR_COUNT];
    logic [10:0] multi_region_height_ff [MR_COUNT];
    logic [10:0] multi_region_x_offset_ff [MR_COUNT];
    logic [10:0] multi_region_y_offset_ff [MR_COUNT];
    logic [MR_COUNT-1:0] multi_region_row_enable_ff;
    logic [MR_COUNT-1:0] multi_region_column_enable_ff;

    logic [31:0] reg_rdata_ff;
    logic [31:0] nxt_reg_rdata;
    applied_type applied_ff;
    applied_type nxt_applied;

    logic [3:0] grp;
    logic [6:0] idx;
    logic [1:0] mr_idx;
    logic mr_idx_ok;
    logic signed [31:0] wv;
    logic wr_ok;
    logic wr_hit;
    logic seq_reset;
    logic [6:0] current_seq_index;
    logic [31:0] current_bus;

    // request decode
    assign grp = reg_req.addr[`GRP_MSB:`GRP_LSB];
    assign idx = reg_req.addr[`IDX_MSB:`IDX_LSB];
    assign mr_idx = reg_req.addr[`MR_IDX_MSB:`IDX_LSB];
    assign mr_idx_ok =
        (reg_req.addr[`MR_IDX_ZERO_MSB:`MR_IDX_ZERO_LSB] == 5'h00);
    assign wv = reg_req.wdata;

    // range check of the addressed parameter; a false result blocks the store
    always_comb begin
        wr_ok = 1'b0;
        wr_hit = 1'b1;
        case (grp)
            `GRP_VBIN: wr_ok = in_range(wv, `VBIN_MIN, COLOR_VARIANT ? `VBIN_MIN : `VBIN_MAX); // R1 R19
            `GRP_LUT_EN: wr_ok = in_range(wv, `ZERO_S32, `FLAG_MAX); // R19
            `GRP_BLACK: wr_ok = in_range(wv, `BLACK_MIN, `BLACK_MAX); // R3 R19
            // colour variant only
            `GRP_RED, `GRP_BLUE: wr_ok = COLOR_VARIANT && in_range(wv, `GAIN_MIN, `GAIN_MAX); // R4 R5 R19
            `GRP_NEXT: wr_ok = in_range(wv, `INDEX_MIN, `INDEX_MAX); // R18 R19
            `GRP_REPEAT: wr_ok = in_range(wv, `REPEAT_MIN, `REPEAT_MAX); // R17 R19
            `GRP_GLOBAL: begin
                case (idx)
                    `GLB_SEND_MODE: wr_ok = in_range(wv, `ZERO_S32, `MODE3_MAX); // R16 R19
                    `GLB_CMD_SELECT: wr_ok = in_range(wv, `INDEX_MIN, `INDEX_MAX); // R6 R19
                    `GLB_SEQ_RESET: wr_ok = (wv == `SEQ_RESET_VALUE); // R8 R19
                    `GLB_SEQ_LUT_MODE: wr_ok = in_range(wv, `ZERO_S32, `FLAG_MAX); // R19
                    `GLB_MR_ENABLE: wr_ok = in_range(wv, `ZERO_S32, `FLAG_MAX); // R19
                    `GLB_LOOKUP_MODE: wr_ok = in_range(wv, `ZERO_S32, `MODE3_MAX); // R15 R19
                    default: wr_hit = 1'b0; // R7
                endcase
            end
            `GRP_MR_WIDTH: wr_ok = mr_idx_ok && in_range(wv, `MR_W_MIN, `MR_W_MAX); // R10 R19
            `GRP_MR_HEIGHT: wr_ok = mr_idx_ok && in_range(wv, `MR_H_MIN, `MR_H_MAX); // R11 R19
            `GRP_MR_XOFF: wr_ok = mr_idx_ok && in_range(wv, `ZERO_S32, `MR_X_MAX); // R12 R19
            `GRP_MR_YOFF: wr_ok = mr_idx_ok && in_range(wv, `ZERO_S32, `MR_Y_MAX); // R13 R19
            `GRP_MR_ROW, `GRP_MR_COL: wr_ok = mr_idx_ok && in_range(wv, `ZERO_S32, `FLAG_MAX); // R14 R19
            default: wr_hit = 1'b0;
        endcase
    end

    // per-index sequence table
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < ENTRIES; i++) begin
                seq_vertical_binning_ff[i] <= `VBIN_DEFAULT; // R20
                seq_index_lookup_enable_ff[i] <= 1'b0;
                seq_black_offset_ff[i] <= 9'sh000;
                seq_red_gain_ff[i] <= 16'sh0000;
                seq_blue_gain_ff[i] <= 16'sh0000;
                seq_next_index_ff[i] <= `INDEX_FIRST;
                seq_frame_repeat_ff[i] <= `REPEAT_DEFAULT;
            end
        end else if (reg_req.wr && wr_ok) begin
            case (grp)
                `GRP_VBIN: seq_vertical_binning_ff[idx] <= wv[1:0]; // R1
                `GRP_LUT_EN: seq_index_lookup_enable_ff[idx] <= wv[0]; // R2
                `GRP_BLACK: seq_black_offset_ff[idx] <= wv[8:0]; // R3
                `GRP_RED: seq_red_gain_ff[idx] <= wv[15:0]; // R4
                `GRP_BLUE: seq_blue_gain_ff[idx] <= wv[15:0]; // R5
                `GRP_NEXT: seq_next_index_ff[idx] <= to_stored(wv); // R18
                `GRP_REPEAT: seq_frame_repeat_ff[idx] <= wv[7:0]; // R17
                default: begin
                end
            endcase
        end
    end

    // global controls
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            video_send_mode_ff <= SEND_NORMAL; // R20
            command_seq_select_ff <= `INDEX_FIRST;
            seq_lookup_mode_ff <= 1'b0;
            multi_region_enable_ff <= 1'b0;
            global_lookup_mode_ff <= LOOKUP_OFF;
        end else if (reg_req.wr && wr_ok &&
            grp == `GRP_GLOBAL) begin
            case (idx)
                `GLB_SEND_MODE: video_send_mode_ff <= wv[1:0]; // R16
                `GLB_CMD_SELECT: command_seq_select_ff <= to_stored(wv); // R6
                `GLB_SEQ_LUT_MODE: seq_lookup_mode_ff <= wv[0]; // R9
                `GLB_MR_ENABLE: multi_region_enable_ff <= wv[0]; // R10
                `GLB_LOOKUP_MODE: global_lookup_mode_ff <= wv[1:0]; // R15
                default: begin
                end
            endcase
        end
    end

    // outcome of the latest write, so software can see a refused value
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_rejected_ff <= 1'b0;
        end else if (reg_req.wr) begin
            wr_rejected_ff <= wr_hit && !wr_ok; // R19
        end
    end

    // multi-region geometry
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < MR_COUNT; i++) begin
                multi_region_width_ff[i] <= `MR_W_DEFAULT; // R20
                multi_region_height_ff[i] <= `MR_H_DEFAULT;
                multi_region_x_offset_ff[i] <= 11'h000;
                multi_region_y_offset_ff[i] <= 11'h000;
            end
            multi_region_row_enable_ff <= '0;
            multi_region_column_enable_ff <= '0;
        end else if (reg_req.wr && wr_ok) begin
            case (grp)
                `GRP_MR_WIDTH: multi_region_width_ff[mr_idx] <= wv[10:0]; // R10
                `GRP_MR_HEIGHT: multi_region_height_ff[mr_idx] <= wv[10:0]; // R11
                `GRP_MR_XOFF: multi_region_x_offset_ff[mr_idx] <= wv[10:0]; // R12
                `GRP_MR_YOFF: multi_region_y_offset_ff[mr_idx] <= wv[10:0]; // R13
                `GRP_MR_ROW: multi_region_row_enable_ff[mr_idx] <= wv[0]; // R14
                `GRP_MR_COL: multi_region_column_enable_ff[mr_idx] <= wv[0]; // R14
                default: begin
                end
            endcase
        end
    end

    // one-cycle strobe
    assign seq_reset = reg_req.wr && wr_ok &&
        grp == `GRP_GLOBAL && idx == `GLB_SEQ_RESET;

    seq_index_sequencer #(
        .IDX_W(7)
    ) u_sequencer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .mode(send_mode_type'(video_send_mode_ff)),
        .frame_start(frame_start),
        .seq_reset(seq_reset), // R8
        .cmd_index(command_seq_select_ff),
        .repeat_count(seq_frame_repeat_ff[current_seq_index]),
        .next_index(seq_next_index_ff[current_seq_index]),
        .current_index(current_seq_index)
    );

    // read mux; unmapped addresses read zero
    always_comb begin
        nxt_reg_rdata = 32'h0;
        case (grp)
            `GRP_VBIN: nxt_reg_rdata = {30'h0, seq_vertical_binning_ff[idx]};
            `GRP_LUT_EN: nxt_reg_rdata = {31'h0, seq_index_lookup_enable_ff[idx]};
            `GRP_BLACK: nxt_reg_rdata = {{23{seq_black_offset_ff[idx][8]}}, seq_black_offset_ff[idx]};
            `GRP_RED: nxt_reg_rdata = {{16{seq_red_gain_ff[idx][15]}}, seq_red_gain_ff[idx]};
            `GRP_BLUE: nxt_reg_rdata = {{16{seq_blue_gain_ff[idx][15]}}, seq_blue_gain_ff[idx]};
            `GRP_NEXT: nxt_reg_rdata = to_bus(seq_next_index_ff[idx]);
            `GRP_REPEAT: nxt_reg_rdata = {24'h0, seq_frame_repeat_ff[idx]};
            `GRP_GLOBAL: begin
                case (idx)
                    `GLB_SEND_MODE: nxt_reg_rdata = {30'h0, video_send_mode_ff};
                    `GLB_CMD_SELECT: nxt_reg_rdata = to_bus(command_seq_select_ff);
                    `GLB_CURRENT: nxt_reg_rdata = to_bus(current_seq_index); // R7
                    `GLB_SEQ_LUT_MODE: nxt_reg_rdata = {31'h0, seq_lookup_mode_ff};
                    `GLB_MR_ENABLE: nxt_reg_rdata = {31'h0, multi_region_enable_ff};
                    `GLB_LOOKUP_MODE: nxt_reg_rdata = {30'h0, global_lookup_mode_ff};
                    `GLB_WR_STATUS: nxt_reg_rdata = {31'h0, wr_rejected_ff};
                    default: nxt_reg_rdata = 32'h0;
                endcase
            end
            `GRP_MR_WIDTH: nxt_reg_rdata = mr_idx_ok ? {21'h0, multi_region_width_ff[mr_idx]} : 32'h0;
            `GRP_MR_HEIGHT: nxt_reg_rdata = mr_idx_ok ? {21'h0, multi_region_height_ff[mr_idx]} : 32'h0;
            `GRP_MR_XOFF: nxt_reg_rdata = mr_idx_ok ? {21'h0, multi_region_x_offset_ff[mr_idx]} : 32'h0;
            `GRP_MR_YOFF: nxt_reg_rdata = mr_idx_ok ? {21'h0, multi_region_y_offset_ff[mr_idx]} : 32'h0;
            `GRP_MR_ROW: nxt_reg_rdata = mr_idx_ok ? {31'h0, multi_region_row_enable_ff[mr_idx]} : 32'h0;
            `GRP_MR_COL: nxt_reg_rdata = mr_idx_ok ? {31'h0, multi_region_column_enable_ff[mr_idx]} : 32'h0;
            default: nxt_reg_rdata = 32'h0;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_ff <= 32'h0;
        end else if (reg_req.rd) begin
            reg_rdata_ff <= nxt_reg_rdata;
        end else begin
            reg_rdata_ff <= 32'h0;
        end
    end

    // 1-based current index
    assign current_bus = to_bus(current_seq_index);

    // settings handed to the pipeline; per-index values only in sequence modes
    always_comb begin
        nxt_applied = '0;
        nxt_applied.mode = send_mode_type'(video_send_mode_ff);
        nxt_applied.index = current_bus[7:0];
        nxt_applied.vbin = `VBIN_DEFAULT;
        nxt_applied.lookup = lookup_type'(global_lookup_mode_ff); // R15
        if (video_send_mode_ff != SEND_NORMAL) begin // R16
            nxt_applied.vbin = seq_vertical_binning_ff[current_seq_index]; // R1
            nxt_applied.black = seq_black_offset_ff[current_seq_index]; // R3
            nxt_applied.red_gain = seq_red_gain_ff[current_seq_index]; // R4
            nxt_applied.blue_gain = seq_blue_gain_ff[current_seq_index]; // R5
            // mode picks gamma or user table
            if (seq_index_lookup_enable_ff[current_seq_index]) begin // R2
                nxt_applied.lookup = seq_lookup_mode_ff ?
                    LOOKUP_USER : LOOKUP_GAMMA; // R9
            end else begin
                nxt_applied.lookup = LOOKUP_OFF;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            applied_ff <= '0;
            // idle shows index 1 and no binning
            applied_ff.index <= `APPLIED_INDEX; // R20
            applied_ff.vbin <= `VBIN_DEFAULT;
        end else begin
            applied_ff <= nxt_applied;
        end
    end

    assign reg_rdata = reg_rdata_ff;
    assign applied = applied_ff;
    assign mr_enable = multi_region_enable_ff; // R10
    assign mr_row_enable = multi_region_row_enable_ff;
    assign mr_column_enable = multi_region_column_enable_ff;

    // geometry from registers
    always_comb begin
        for (int i = 0; i < MR_COUNT; i++) begin
            mr_width[i] = multi_region_width_ff[i];
            mr_height[i] = multi_region_height_ff[i];
            mr_x_offset[i] = multi_region_x_offset_ff[i];
            mr_y_offset[i] = multi_region_y_offset_ff[i];
        end
    end

endmodule : sequence_roi_parameter_bank
`default_nettype wire

//--- dv/sequence_roi_parameter_bank_chk.sv
`default_nettype none
module sequence_roi_parameter_bank_chk
    import seq_roi_pkg::*;
#(
    parameter int MR_COUNT = 4,
    parameter bit COLOR_VARIANT = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire reg_req_type reg_req,
    input wire logic [31:0] reg_rdata,
    input wire logic frame_start,
    input wire applied_type applied,
    input wire logic [MR_COUNT-1:0][10:0] mr_width,
    input wire logic [MR_COUNT-1:0][10:0] mr_y_offset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_no_read;
        !reg_req.rd;
    endsequence
    property p_quiet;
        s_no_read |=> reg_rdata == 32'h0;
    endproperty
    a_rdata_quiet: assert property (p_quiet) else $error("read data outside read slot");
    a_vbin_legal: assert property (applied.vbin inside {2'h1, 2'h2}) else $error("binning illegal");
    a_black_legal: assert property (applied.black >= -9'sh85 && applied.black <= 9'shff)
        else $error("black offset out of range");
    a_gain_mono: assert property (!COLOR_VARIANT |-> applied.red_gain == 16'h0 && applied.blue_gain == 16'h0)
        else $error("gain nonzero on mono");
    a_index_legal: assert property (applied.index >= 8'h01 && applied.index <= 8'h80)
        else $error("index out of range");
    a_normal_plain: assert property (applied.mode == SEND_NORMAL |-> applied.vbin == 2'h1 && applied.black == 9'h0)
        else $error("sequence values leak into normal mode");
    a_index_cause: assert property ($changed(applied.index) |-> $past(frame_start, 2) || $past(reg_req.wr, 2))
        else $error("index moved without cause");
    a_width_legal: assert property (mr_width[0] >= 11'h010 && mr_width[0] <= 11'h790)
        else $error("width out of range");
    a_yoff_legal: assert property (mr_y_offset[0] <= 11'h4be) else $error("y offset out of range");
endmodule : sequence_roi_parameter_bank_chk
bind sequence_roi_parameter_bank sequence_roi_parameter_bank_chk #(.MR_COUNT(MR_COUNT),
    .COLOR_VARIANT(COLOR_VARIANT)) chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .frame_start(frame_start), .applied(applied), .mr_width(mr_width),
    .mr_y_offset(mr_y_offset));
`default_nettype wire

//--- dv/seq_host_model.sv
`default_nettype none
module seq_host_model
    import seq_roi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [31:0] reg_rdata,
    output reg_req_type reg_req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial reg_req = '0;
    // selection and reset are plain writes
    task automatic wr(input logic [10:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_req.addr <= a;
        reg_req.wdata <= v;
        reg_req.wr <= 1'b1;
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
        reg_req.wdata <= ~v;
    endtask : wr
    task automatic rd(input logic [10:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_req.addr <= a;
        reg_req.rd <= 1'b1;
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
endmodule : seq_host_model
`default_nettype wire

//--- dv/sequence_roi_parameter_bank_test.sv
`default_nettype none
module sequence_roi_parameter_bank_test
    import seq_roi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic frame_start = 1'b0;
    reg_req_type reg_req;
    logic [31:0] reg_rdata;
    applied_type ap;
    logic mr_enable;
    logic [3:0][10:0] mr_width;
    logic [3:0] mr_row_enable;
    logic [3:0] mr_column_enable;
    int err_total = 0;
    int check_count = 0;
    seq_host_model host_u (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_req(reg_req));
    sequence_roi_parameter_bank dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .frame_start(frame_start), .applied(ap), .mr_enable(mr_enable),
        .mr_width(mr_width), .mr_height(), .mr_x_offset(), .mr_y_offset(),
        .mr_row_enable(mr_row_enable), .mr_column_enable(mr_column_enable));
    initial forever #12.5 clk_sys = ~clk_sys;
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk
    task automatic rchk(input logic [10:0] a, input logic [31:0] e);
        logic [31:0] d;
        host_u.rd(a, d);
        chk("register", e, d);
    endtask : rchk
    // write, read back, then read the rejection flag unless r is 2
    task automatic step(input logic [10:0] a, input logic [31:0] v, input logic [31:0] e, input logic [1:0] r);
        host_u.wr(a, v);
        rchk(a, e);
        if (r != 2'h2) rchk(11'h387, {30'h0, r});
    endtask : step
    task automatic fs;
        @(posedge clk_sys);
        frame_start <= 1'b1;
        @(posedge clk_sys);
        frame_start <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : fs
    task automatic t_defaults;
        rchk(11'h000, 32'h1);
        rchk(11'h07f, 32'h1);
        rchk(11'h080, 32'h0);
        rchk(11'h100, 32'h0);
        rchk(11'h280, 32'h1);
        rchk(11'h300, 32'h1);
        rchk(11'h382, 32'h1);
        rchk(11'h384, 32'h0);
        rchk(11'h386, 32'h0);
        rchk(11'h403, 32'h790);
        rchk(11'h480, 32'h4c0);
        rchk(11'h500, 32'h0);
        rchk(11'h683, 32'h0);
        chk("mr_enable", 32'h0, {31'h0, mr_enable});
    endtask : t_defaults
    task automatic t_limits;
        step(11'h100, 32'hffffff7b, 32'hffffff7b, 2'h0);
        step(11'h100, 32'hffffff7a, 32'hffffff7b, 2'h1);
        step(11'h100, 32'h100, 32'hffffff7b, 2'h1);
        step(11'h100, 32'hff, 32'hff, 2'h0);
        step(11'h000, 32'h2, 32'h2, 2'h0);
        step(11'h000, 32'h3, 32'h2, 2'h1);
        step(11'h400, 32'h10, 32'h10, 2'h0);
        step(11'h400, 32'hf, 32'h10, 2'h1);
        step(11'h403, 32'h791, 32'h790, 2'h1);
        step(11'h480, 32'h1, 32'h4c0, 2'h1);
        step(11'h480, 32'h2, 32'h2, 2'h0);
        step(11'h500, 32'h781, 32'h0, 2'h1);
        step(11'h500, 32'h780, 32'h780, 2'h0);
        step(11'h583, 32'h4bf, 32'h0, 2'h1);
        step(11'h583, 32'h4be, 32'h4be, 2'h0);
        step(11'h180, 32'h4531, 32'h0, 2'h2);
        step(11'h200, 32'h1, 32'h0, 2'h2);
        step(11'h382, 32'h5, 32'h1, 2'h0);
        step(11'h383, 32'h0, 32'h0, 2'h2);
        step(11'h604, 32'h1, 32'h0, 2'h1);
        step(11'h380, 32'h3, 32'h0, 2'h1);
    endtask : t_limits
    task automatic t_trigger;
        host_u.wr(11'h280, 32'h5);
        host_u.wr(11'h300, 32'h2);
        host_u.wr(11'h284, 32'h3);
        host_u.wr(11'h004, 32'h2);
        host_u.wr(11'h104, 32'h7);
        host_u.wr(11'h380, 32'h1);
        fs();
        chk("index", 32'h1, {24'h0, ap.index});
        fs();
        chk("index", 32'h5, {24'h0, ap.index});
        chk("vbin", 32'h2, {30'h0, ap.vbin});
        chk("black", 32'h7, {23'h0, ap.black});
        fs();
        rchk(11'h382, 32'h3);
        host_u.wr(11'h383, 32'h0);
        rchk(11'h382, 32'h1);
        host_u.wr(11'h080, 32'h1);
        host_u.wr(11'h384, 32'h1);
        fs();
        chk("lookup", {30'h0, LOOKUP_USER}, {30'h0, ap.lookup});
        host_u.wr(11'h384, 32'h0);
        host_u.wr(11'h084, 32'h1);
        fs();
        chk("lookup", {30'h0, LOOKUP_GAMMA}, {30'h0, ap.lookup});
    endtask : t_trigger
    task automatic t_command;
        host_u.wr(11'h383, 32'h0);
        host_u.wr(11'h381, 32'h9);
        host_u.wr(11'h380, 32'h2);
        repeat (2) @(posedge clk_sys);
        #1 chk("index", 32'h1, {24'h0, ap.index});
        fs();
        chk("index", 32'h9, {24'h0, ap.index});
        chk("mode", 32'h2, {30'h0, ap.mode});
        step(11'h381, 32'h81, 32'h9, 2'h1);
        fs();
        chk("index", 32'h9, {24'h0, ap.index});
        host_u.wr(11'h380, 32'h0);
        step(11'h386, 32'h3, 32'h0, 2'h1);
        host_u.wr(11'h386, 32'h2);
        fs();
        chk("lookup", {30'h0, LOOKUP_USER}, {30'h0, ap.lookup});
        chk("vbin", 32'h1, {30'h0, ap.vbin});
    endtask : t_command
    task automatic t_multi;
        host_u.wr(11'h385, 32'h1);
        host_u.wr(11'h601, 32'h1);
        host_u.wr(11'h683, 32'h1);
        host_u.wr(11'h401, 32'h64);
        @(posedge clk_sys);
        #1 chk("mr_enable", 32'h1, {31'h0, mr_enable});
        chk("row", 32'h2, {28'h0, mr_row_enable});
        chk("column", 32'h8, {28'h0, mr_column_enable});
        chk("width", 32'h64, {21'h0, mr_width[1]});
    endtask : t_multi
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_defaults();
        t_limits();
        t_trigger();
        t_command();
        t_multi();
        test_done();
    end
endmodule : sequence_roi_parameter_bank_test
`default_nettype wire
